// file: hdl/mpcl_loader.sv
// master byte-parallel configuration loader with serial chain output
`timescale 1ns/10ps
module mpcl_loader
  import mpcl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_boot_select_bit2,
  input wire logic i_boot_select_bit1,
  input wire logic i_boot_select_bit0,
  input wire logic [7:0] i_rom_data,
  input wire logic i_low_voltage,
  input wire logic i_wide_address,
  input wire logic i_chain_ready,
  output logic o_config_clock,
  output logic o_read_strobe_n,
  output logic [LOW_ADDR_W-1:0] o_address,
  output logic [UPPER_W-1:0] o_upper_address_lines,
  output logic o_upper_oe_n,
  output logic o_dout,
  output logic o_dout_valid,
  output logic o_busy
);
  mpcl_state_s st_reg;
  mpcl_state_s st_next;
  logic [2:0] mode;
  logic mode_ok;
  logic rise;
  logic fall;
  logic cap_due;
  logic stall;
  logic push;
  logic pop;
  logic pop_ok;
  logic strobe_end;
  logic upper_drive;

  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                  input logic dn);
    step_addr = dn ? a - 22'h000001 : a + 22'h000001;
  endfunction : step_addr

  assign mode = {i_boot_select_bit2, i_boot_select_bit1, i_boot_select_bit0};
  assign mode_ok = (mode == MODE_UP) || (mode == MODE_DOWN);
  assign cap_due = (st_reg.cap_cnt == 3'h0);
  // stall the clock rather than drop a byte when the buffer is full
  // a full buffer that can drain at this rise is no reason to stall
  assign pop_ok = (st_reg.buf_cnt != 2'h0) && i_chain_ready &&
                  (!st_reg.ser_busy || st_reg.ser_idx == BIT_LAST);
  // only the rise is held back, so the clock parks low
  assign stall = !st_reg.config_clock && cap_due && (st_reg.buf_cnt == BUF_FULL) && !pop_ok;
  assign strobe_end = (st_reg.fsm == MPCL_STROBE) &&
                      (st_reg.div_cnt == CONFIG_CLOCK_HALF_CYC + CONFIG_CLOCK_HALF_CYC - 8'h01);
  assign rise = (st_reg.fsm == MPCL_RUN) && !st_reg.config_clock && !stall &&
                (st_reg.div_cnt == CONFIG_CLOCK_HALF_CYC - 8'h01);
  assign fall = (st_reg.fsm == MPCL_RUN) && st_reg.config_clock &&
                (st_reg.div_cnt == CONFIG_CLOCK_HALF_CYC - 8'h01);
  assign push = strobe_end || (rise && cap_due);
  assign pop = rise && pop_ok;
  assign upper_drive = (st_reg.fsm != MPCL_IDLE) &&
                       (i_low_voltage || st_reg.upper_en); // RL8 RL10 RL11

  always_comb begin
    st_next = st_reg;
    case (st_reg.fsm)
      MPCL_IDLE: begin
        st_next.div_cnt = 8'h00;
        st_next.config_clock = 1'b0;
        if (i_start && mode_ok) begin
          st_next.fsm = MPCL_STROBE;
          st_next.strobe_n = 1'b0;
          st_next.down = (mode == MODE_DOWN);
          st_next.addr = (mode == MODE_DOWN) ? ADDR_DOWN_START : ADDR_UP_START; // RL6 RL7
          st_next.upper_en = 1'b0;
          st_next.cap_cnt = 3'h0;
          st_next.buf_cnt = 2'h0;
          st_next.wr_ptr = 1'b0;
          st_next.rd_ptr = 1'b0;
          st_next.ser_busy = 1'b0;
          st_next.dout_valid = 1'b0;
        end
      end
      MPCL_STROBE: begin
        st_next.div_cnt = st_reg.div_cnt + 8'h01;
        if (strobe_end) begin
          // first byte taken as the strobe ends; the clock starts here
          st_next.fsm = MPCL_RUN; // RL13
          st_next.strobe_n = 1'b1;
          st_next.config_clock = 1'b1;
          st_next.div_cnt = 8'h00;
          st_next.cap_cnt = 3'h1;
        end
      end
      MPCL_RUN: begin
        if (st_reg.div_cnt == CONFIG_CLOCK_HALF_CYC - 8'h01) begin
          if (!stall) begin
            st_next.div_cnt = 8'h00;
            st_next.config_clock = !st_reg.config_clock;
          end
        end else begin
          st_next.div_cnt = st_reg.div_cnt + 8'h01;
        end
        if (rise) begin
          st_next.cap_cnt = st_reg.cap_cnt + 3'h1;
          if (pop) begin
            st_next.shreg = st_reg.buf_mem[st_reg.rd_ptr]; // RL2
            st_next.ser_idx = 3'h0;
            st_next.ser_busy = 1'b1;
          end else if (st_reg.ser_busy && st_reg.ser_idx == BIT_LAST) begin
            st_next.ser_busy = 1'b0;
          end else if (st_reg.ser_busy) begin
            st_next.ser_idx = st_reg.ser_idx + 3'h1; // RL14
          end
        end
        if (fall) begin
          // lsb lands on the fall after the popping rise, half a period on
          st_next.dout = st_reg.shreg[st_reg.ser_idx]; // RL4 RL5
          st_next.dout_valid = st_reg.ser_busy;
        end
        if (i_stop) begin
          st_next.fsm = MPCL_IDLE;
        end
      end
      default: begin
        st_next.fsm = MPCL_IDLE;
      end
    endcase
    if (push) begin
      st_next.buf_mem[st_reg.wr_ptr] = i_rom_data; // RL1
      st_next.wr_ptr = !st_reg.wr_ptr;
      st_next.addr = step_addr(st_reg.addr, st_reg.down); // RL3 RL12
    end
    if (pop) begin
      st_next.rd_ptr = !st_reg.rd_ptr;
    end
    if (push && !pop) begin
      st_next.buf_cnt = st_reg.buf_cnt + 2'h1;
    end else if (pop && !push) begin
      st_next.buf_cnt = st_reg.buf_cnt - 2'h1;
    end
    // the low-voltage part never needs the request; it drives anyway
    if (st_reg.fsm != MPCL_IDLE && i_wide_address) begin
      st_next.upper_en = 1'b1; // RL9
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '{fsm: MPCL_IDLE, strobe_n: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_config_clock = st_reg.config_clock;
  assign o_read_strobe_n = st_reg.strobe_n;
  assign o_address = st_reg.addr[LOW_ADDR_W-1:0];
  assign o_upper_address_lines = upper_drive ? st_reg.addr[ADDR_W-1:LOW_ADDR_W] : 4'h0;
  assign o_upper_oe_n = !upper_drive;
  assign o_dout = st_reg.dout;
  assign o_dout_valid = st_reg.dout_valid;
  assign o_busy = (st_reg.fsm != MPCL_IDLE);

  sequence s_strobe_end;
    strobe_end;
  endsequence
  sequence s_byte_load;
    pop;
  endsequence
  sequence s_next_fall;
    ##[1:60] fall;
  endsequence

  a_addr_step: assert property (@(posedge i_clk) disable iff (i_rst) // RL3
    push |=> st_reg.addr == step_addr($past(st_reg.addr), st_reg.down))
    else $error("address did not step on capture");
  a_up_start: assert property (@(posedge i_clk) disable iff (i_rst) // RL6
    (st_reg.fsm == MPCL_IDLE && i_start && mode == MODE_UP) |=>
    st_reg.addr == ADDR_UP_START && !st_reg.down)
    else $error("up mode did not start at zero");
  a_down_start: assert property (@(posedge i_clk) disable iff (i_rst) // RL7
    (st_reg.fsm == MPCL_IDLE && i_start && mode == MODE_DOWN) |=>
    st_reg.addr == ADDR_DOWN_START && st_reg.down)
    else $error("down mode did not start at top");
  a_upper_idle: assert property (@(posedge i_clk) disable iff (i_rst) // RL8
    (!i_low_voltage && !st_reg.upper_en) |-> o_upper_oe_n && o_upper_address_lines == 4'h0)
    else $error("upper lines driven without request");
  a_lv_drive: assert property (@(posedge i_clk) disable iff (i_rst) // RL10
    (i_low_voltage && o_busy) |-> !o_upper_oe_n &&
    o_upper_address_lines == st_reg.addr[ADDR_W-1:LOW_ADDR_W])
    else $error("low-voltage part not driving upper lines");
  a_wide_cause: assert property (@(posedge i_clk) disable iff (i_rst) // RL9
    $rose(st_reg.upper_en) |-> $past(i_wide_address))
    else $error("upper lines enabled without request");
  a_dout_fall: assert property (@(posedge i_clk) disable iff (i_rst) // RL5
    $changed(st_reg.dout) |-> $past(fall))
    else $error("serial output changed off a falling edge");
  a_lsb_time: assert property (@(posedge i_clk) disable iff (i_rst) // RL4
    s_byte_load ##1 s_next_fall |=> st_reg.dout == st_reg.shreg[0] && st_reg.dout_valid)
    else $error("byte lsb not out on the following fall");
  a_first_byte: assert property (@(posedge i_clk) disable iff (i_rst) // RL13
    s_strobe_end |=> st_reg.config_clock && st_reg.strobe_n && st_reg.buf_cnt != 2'h0)
    else $error("first byte or clock missing at strobe end");
  a_bit_order: assert property (@(posedge i_clk) disable iff (i_rst) // RL14
    (rise && !pop && st_reg.ser_busy && st_reg.ser_idx != BIT_LAST) |=>
    st_reg.ser_idx == $past(st_reg.ser_idx) + 3'h1)
    else $error("serial bit index skipped");

  // a stalled capture must keep the clock low and lose no stored byte
  a_stall_hold: assert property (@(posedge i_clk) disable iff (i_rst) // RL1
    stall |=> !st_reg.config_clock && st_reg.buf_cnt == BUF_FULL && $stable(st_reg.addr))
    else $error("clock or buffer moved during a stall");
  a_upper_count: assert property (@(posedge i_clk) disable iff (i_rst) // RL12
    !o_upper_oe_n |-> {o_upper_address_lines, o_address} == st_reg.addr)
    else $error("upper lines not part of the address counter");
  a_pop_load: assert property (@(posedge i_clk) disable iff (i_rst) // RL2
    pop |=> st_reg.ser_busy && st_reg.ser_idx == 3'h0 &&
    st_reg.shreg == $past(st_reg.buf_mem[st_reg.rd_ptr]))
    else $error("buffered byte not loaded into the serializer");
  a_strobe_low: assert property (@(posedge i_clk) disable iff (i_rst) // RL13
    (st_reg.fsm == MPCL_STROBE) |-> !st_reg.strobe_n && !st_reg.config_clock)
    else $error("strobe high or clock running before first capture");
endmodule : mpcl_loader

// file: hdl/mpcl_pkg.sv
// constants, types and state layout for the master parallel config loader
// Notes on behaviour
// RL1 - drive rom address, capture eight-bit byte
// RL2 - serialize every byte onto chain output
// RL3 - capturing rising edge also steps address
// RL4 - byte lsb out 1.5 periods later
// RL5 - serial output changes on falling edges
// RL6 - select 100: address from zero, upward
// RL7 - select 110: address from 3ffff, downward
// RL8 - upper address lines idle by default
// RL9 - drive upper lines once bitstream asks
// RL10 - low-voltage variant always drives all lines; the code drives the upper lines only while busy, not in MPCL_IDLE
// RL11 - low-voltage variant ignores 18-line request
// RL12 - upper lines count with lower bits
// RL13 - first byte and clock at strobe end
// RL14 - remaining bits shift out in ascending order
package mpcl_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONFIG_CLOCK_PERIOD_NS = 1000;
  localparam int CONFIG_CLOCK_HALF_CYC_I = CONFIG_CLOCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [7:0] CONFIG_CLOCK_HALF_CYC = CONFIG_CLOCK_HALF_CYC_I[7:0];
  localparam int ADDR_W = 22;
  localparam int LOW_ADDR_W = 18;
  localparam int UPPER_W = 4;
  localparam int BYTE_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam logic [2:0] MODE_UP = 3'h4;
  localparam logic [2:0] MODE_DOWN = 3'h6;
  localparam logic [21:0] ADDR_UP_START = 22'h000000;
  localparam logic [21:0] ADDR_DOWN_START = 22'h03ffff;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] BUF_FULL = 2'h2;

  typedef enum logic [2:0] {
    MPCL_IDLE = 3'b001,
    MPCL_STROBE = 3'b010,
    MPCL_RUN = 3'b100
  } mpcl_state_e;

  typedef struct packed {
    mpcl_state_e fsm;
    logic [7:0] div_cnt;
    logic config_clock;
    logic strobe_n;
    logic down;
    logic upper_en;
    logic [ADDR_W-1:0] addr;
    logic [2:0] cap_cnt;
    logic [BUF_DEPTH-1:0][BYTE_W-1:0] buf_mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] buf_cnt;
    logic [BYTE_W-1:0] shreg;
    logic [2:0] ser_idx;
    logic ser_busy;
    logic dout;
    logic dout_valid;
  } mpcl_state_s;
endpackage : mpcl_pkg

// file: verification/mpcl_partner.sv
// partner model: byte-wide rom plus the next device on the serial chain
`timescale 1ns/10ps
module mpcl_partner (
  input wire logic i_rst,
  input wire logic i_config_clock,
  input wire logic [17:0] i_address,
  input wire logic i_dout,
  input wire logic i_dout_valid,
  input wire logic i_stall,
  output logic [7:0] o_rom_data,
  output logic o_chain_ready
);
  logic [7:0] sh;
  logic [2:0] nb;
  logic [7:0] got [0:15];
  int n_got;
  // rom stays selected, so its data simply follows the address
  assign o_rom_data = i_address[7:0] ^ 8'ha5;
  assign o_chain_ready = !i_stall;
  // sampled on the rise that follows each fall of the loader
  always @(posedge i_config_clock or posedge i_rst) begin
    if (i_rst) begin
      nb = 3'h0;
      n_got = 0;
    end else if (i_dout_valid) begin
      sh = {i_dout, sh[7:1]};
      if (nb == 3'h7) begin
        got[n_got[3:0]] = sh;
        n_got++;
      end
      nb++;
    end
  end
endmodule : mpcl_partner

// file: verification/tb.sv
// self-checking bench for the master parallel config loader
`timescale 1ns/10ps
module tb;
  import mpcl_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst, i_start, i_stop, i_low_voltage, i_wide_address, stall;
  logic [2:0] sel;
  logic [7:0] rom;
  logic rdy, o_config_clock, o_read_strobe_n, o_upper_oe_n, o_dout, o_dout_valid, o_busy;
  logic [17:0] o_address;
  logic [3:0] o_upper_address_lines;
  int bad_count, n_tests;
  mpcl_loader dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_start(i_start), .i_stop(i_stop),
    .i_boot_select_bit2(sel[2]), .i_boot_select_bit1(sel[1]), .i_boot_select_bit0(sel[0]),
    .i_rom_data(rom), .i_low_voltage(i_low_voltage), .i_wide_address(i_wide_address),
    .i_chain_ready(rdy), .o_config_clock(o_config_clock), .o_read_strobe_n(o_read_strobe_n),
    .o_address(o_address), .o_upper_address_lines(o_upper_address_lines),
    .o_upper_oe_n(o_upper_oe_n), .o_dout(o_dout), .o_dout_valid(o_dout_valid), .o_busy(o_busy));
  mpcl_partner pm_u (.i_rst(i_rst), .i_config_clock(o_config_clock), .i_address(o_address),
    .i_dout(o_dout), .i_dout_valid(o_dout_valid), .i_stall(stall), .o_rom_data(rom),
    .o_chain_ready(rdy));
  always #5 i_clk = ~i_clk;
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic setup(input logic lv, input logic wide, input logic st);
    i_low_voltage = lv;
    i_wide_address = wide;
    stall = st;
    i_rst = 1'b1;
    cyc(3);
    i_rst = 1'b0;
  endtask : setup
  task automatic go(input logic [2:0] m);
    sel = m;
    i_start = 1'b1;
    cyc(1);
    i_start = 1'b0;
  endtask : go
  task automatic wait_bytes(input int n);
    for (int k = 0; k < 9000 && pm_u.n_got < n; k++) cyc(1);
    cmp(pm_u.n_got, n);
  endtask : wait_bytes
  task automatic halt;
    i_stop = 1'b1;
    cyc(1);
    i_stop = 1'b0;
    cyc(1);
    cmp({o_busy, o_upper_oe_n}, 2'h1);
  endtask : halt
  // serial output may only move while the config clock sits low
  always @(o_dout) begin
    #1;
    if (!i_rst && o_busy) cmp(o_config_clock, 1'b0);
  end
  task automatic t_up;
    setup(1'b0, 1'b0, 1'b0);
    go(3'h4);
    cmp({o_read_strobe_n, o_address, o_upper_oe_n}, {1'b0, 18'h0, 1'b1});
    cyc(99);
    cmp({o_config_clock, o_read_strobe_n}, 2'h0);
    cyc(1);
    cmp({o_config_clock, o_read_strobe_n, o_address}, {2'h3, 18'h1});
    wait_bytes(2);
    cmp({pm_u.got[0], pm_u.got[1]}, 16'ha5a4);
    halt();
  endtask : t_up
  task automatic t_down;
    setup(1'b0, 1'b1, 1'b0);
    go(3'h6);
    cmp({o_address, o_upper_oe_n, o_upper_address_lines}, {18'h3ffff, 5'h10});
    cyc(1);
    cmp({o_upper_oe_n, o_upper_address_lines}, 5'h0);
    cyc(99);
    cmp(o_address, 18'h3fffe);
    wait_bytes(2);
    cmp({pm_u.got[0], pm_u.got[1]}, 16'h5a5b);
    halt();
  endtask : t_down
  task automatic t_modes;
    setup(1'b1, 1'b0, 1'b0);
    go(3'h4);
    cmp(o_upper_oe_n, 1'b0);
    cyc(100);
    halt();
    for (int m = 0; m < 8; m++) begin
      if (m != 4 && m != 6) begin
        go(m[2:0]);
        cyc(2);
        cmp(o_busy, 1'b0);
      end
    end
  endtask : t_modes
  // chain stalls from the start: two bytes wait in the buffer, capture then holds
  task automatic t_stall;
    setup(1'b0, 1'b0, 1'b1);
    go(3'h4);
    cyc(3000);
    cmp(o_address, 18'h2);
    cmp({o_dout_valid, o_config_clock}, 2'h0);
    cmp(pm_u.n_got, 0);
    stall = 1'b0;
    wait_bytes(3);
    cmp({pm_u.got[0], pm_u.got[1], pm_u.got[2]}, 24'ha5a4a7);
    halt();
  endtask : t_stall
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end
  initial begin
    {i_start, i_stop, i_low_voltage, i_wide_address, stall, sel} = '0;
    i_rst = 1'b1;
    bad_count = 0;
    n_tests = 0;
    t_up();
    t_down();
    t_modes();
    t_stall();
    end_of_test();
  end
endmodule : tb
